// ---- rtl/sac_pkg.sv ----
// Constants and types shared by the converter control block.
// Assumes a 200 MHz ref_clk and an APB master with 32-bit data.
package sac_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] OPT_OFS = 8'h00;
	localparam logic [7:0] CTRL_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam logic [7:0] RES_OFS = 8'h20;
	localparam logic [2:0] RES_PAGE = 3'h1;

	// ----------------------------------------
	// Field layout and reset values
	// ----------------------------------------
	typedef struct packed {
		logic pwr_up;
		logic alt_clk;
		logic irq_edge;
		logic stop_dly;
		logic [1:0] unused;
		logic [1:0] wdog_rate;
	} sac_option_type;

	localparam logic [7:0] OPT_RST = 8'h10;
	localparam int CH_LSB = 0;
	localparam int CH_W = 4;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 7;

	// ----------------------------------------
	// Sizes and timing
	// ----------------------------------------
	localparam int NUM_CH = 8;
	localparam int RES_BITS = 8;
	localparam int MUX_INPUTS = 16;
	localparam int PROT_CYCLES = 64;
	localparam int CLK_MHZ = 200;
	localparam int SETTLE_US = 100;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	localparam int BUS_DIV = 4;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_COMPARE
	} sac_state_type;
endpackage : sac_pkg

// ---- rtl/sac_top.sv ----
// Control logic of an 8-channel 8-bit successive-approximation converter.
// Assumes an APB master on ref_clk, an external comparator and an RC clock pin.
//
// The register offsets and the APB register port were chosen for this implementation.

// Contract
// - Eight-bit results, eight external analog channels over one shared input path.
// - Step timing comes from the bus clock or from the RC oscillator.
// - Alternate clock select picks converter timing and charge pump clock.
// - Multiplexer routes one of sixteen inputs, chosen by channel select field.
// - Eight pins are input-only analog sources; other inputs are internal lines.
// - Eight comparison steps, MSB first, each deciding one approximation bit.
// - Sample held for the whole sequence; comparison code driven each step.
// - Last step copies the finished approximation, or zero if a start falls in that cycle, into that conversion's result register.
// - Power-up bit enables charge pump; clear means converter unpowered.
// - Protected option bits: one write in first 64 cycles, special modes anytime.
// - Reset clears power-up bit, leaving the converter disabled.
module sac_top #(
	parameter int BUS_DIV = sac_pkg::BUS_DIV
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic special_mode_pin,
	input wire logic rc_osc_pin,
	input wire logic comp_pin,
	output logic [sac_pkg::CH_W-1:0] mux_sel,
	output logic [sac_pkg::RES_BITS-1:0] dac_code,
	output logic sample_gate,
	output logic pump_enable,
	output logic pump_alt_clock,
	output logic irq_edge_select,
	output logic stop_recovery_delay,
	output logic [1:0] watchdog_rate_field
);
	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	if (BUS_DIV < 3 || BUS_DIV > 256) begin : g_bad_div
		$error("BUS_DIV out of range");
	end

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [1:0] mode_sync_q;
	logic [2:0] rc_sync_q;
	logic [1:0] comp_sync_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode_sync_q <= 2'h0;
			rc_sync_q <= 3'h0;
			comp_sync_q <= 2'h0;
		end else begin
			mode_sync_q <= {mode_sync_q[0], special_mode_pin};
			rc_sync_q <= {rc_sync_q[1:0], rc_osc_pin};
			comp_sync_q <= {comp_sync_q[0], comp_pin};
		end
	end
	wire comp_hi = comp_sync_q[1];
	wire rc_tick = rc_sync_q[1] & ~rc_sync_q[2];

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic pready_q;
	wire acc = psel & penable & pready_q;
	wire aligned = paddr[1:0] == 2'h0;
	wire hit_opt = aligned & (paddr == sac_pkg::OPT_OFS);
	wire hit_ctrl = aligned & (paddr == sac_pkg::CTRL_OFS);
	wire hit_stat = aligned & (paddr == sac_pkg::STAT_OFS);
	wire hit_res = aligned & (paddr[7:5] == sac_pkg::RES_PAGE);
	wire mapped = hit_opt | hit_ctrl | hit_stat | hit_res;
	wire wr_opt = acc & pwrite & hit_opt;
	wire wr_ctrl = acc & pwrite & hit_ctrl;

	// ----------------------------------------
	// Option register and write protection
	// ----------------------------------------
	sac_pkg::sac_option_type opt_q;
	sac_pkg::sac_option_type opt_d;
	sac_pkg::sac_option_type wr_val;
	logic [6:0] prot_cnt_q;
	logic prot_used_q;
	logic special_q;
	logic mode_taken_q;
	wire prot_open = special_q | (~prot_used_q & (prot_cnt_q < 7'(sac_pkg::PROT_CYCLES)));
	assign wr_val = pwdata[7:0];

	always_comb begin
		opt_d = opt_q;
		if (wr_opt) begin
			opt_d.pwr_up = wr_val.pwr_up;
			opt_d.alt_clk = wr_val.alt_clk;
			if (prot_open) begin
				opt_d.irq_edge = wr_val.irq_edge;
				opt_d.stop_dly = wr_val.stop_dly;
				opt_d.wdog_rate = wr_val.wdog_rate;
			end
		end
		opt_d.unused = 2'h0;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			opt_q <= sac_pkg::OPT_RST;
			prot_cnt_q <= 7'h00;
			prot_used_q <= 1'b0;
			special_q <= 1'b0;
			mode_taken_q <= 1'b0;
		end else begin
			opt_q <= opt_d;
			if (prot_cnt_q < 7'(sac_pkg::PROT_CYCLES)) begin
				prot_cnt_q <= prot_cnt_q + 7'h01;
			end
			if (wr_opt) begin
				prot_used_q <= 1'b1;
			end
			if (!mode_taken_q && prot_cnt_q == 7'h02) begin
				special_q <= mode_sync_q[1];
				mode_taken_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Step clock selection
	// ----------------------------------------
	logic [7:0] div_q;
	wire bus_tick = div_q == 8'(BUS_DIV - 1);
	wire step = opt_q.alt_clk ? rc_tick : bus_tick;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_q <= 8'h00;
		end else begin
			div_q <= bus_tick ? 8'h00 : div_q + 8'h01;
		end
	end

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	sac_pkg::sac_state_type st_q;
	sac_pkg::sac_state_type st_d;
	logic [sac_pkg::CH_W-1:0] ch_q;
	logic [7:0] sar_q;
	logic [7:0] sar_d;
	logic [2:0] bit_q;
	logic done_q;
	logic [7:0] res_q [sac_pkg::NUM_CH];
	wire start = wr_ctrl & opt_q.pwr_up;
	wire last = (st_q == sac_pkg::ST_COMPARE) & step & (bit_q == 3'h0);
	wire [7:0] bit_mask = 8'h01 << bit_q;
	wire [7:0] next_mask = 8'h01 << (bit_q - 3'h1);

	always_comb begin
		st_d = st_q;
		sar_d = sar_q;
		case (st_q)
			sac_pkg::ST_IDLE: begin
			end
			sac_pkg::ST_SAMPLE: begin
				if (step) begin
					st_d = sac_pkg::ST_COMPARE;
					sar_d = 8'h80;
				end
			end
			sac_pkg::ST_COMPARE: begin
				if (step) begin
					sar_d = comp_hi ? sar_q : (sar_q & ~bit_mask);
					if (bit_q != 3'h0) begin
						sar_d = sar_d | next_mask;
					end else begin
						st_d = sac_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				st_d = sac_pkg::ST_IDLE;
			end
		endcase
		if (start) begin
			st_d = sac_pkg::ST_SAMPLE;
			sar_d = 8'h00;
		end
		if (!opt_q.pwr_up) begin
			st_d = sac_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q <= sac_pkg::ST_IDLE;
			sar_q <= 8'h00;
			bit_q <= 3'h7;
			ch_q <= 4'h0;
			done_q <= 1'b0;
		end else begin
			st_q <= st_d;
			sar_q <= sar_d;
			if (start) begin
				bit_q <= 3'h7;
				ch_q <= pwdata[sac_pkg::CH_LSB +: sac_pkg::CH_W];
			end else if (st_q == sac_pkg::ST_COMPARE && step && bit_q != 3'h0) begin
				bit_q <= bit_q - 3'h1;
			end
			if (last) begin
				done_q <= 1'b1;
			end else if (start) begin
				done_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Result registers
	// ----------------------------------------
	for (genvar i = 0; i < sac_pkg::NUM_CH; i++) begin : g_res
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				res_q[i] <= 8'h00;
			end else if (last && ch_q[2:0] == 3'(i)) begin
				res_q[i] <= sar_d;
			end
		end
	end

	// ----------------------------------------
	// Analog-side outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mux_sel <= 4'h0;
			dac_code <= 8'h00;
			sample_gate <= 1'b0;
			pump_enable <= 1'b0;
			pump_alt_clock <= 1'b0;
			irq_edge_select <= 1'b0;
			stop_recovery_delay <= 1'b1;
			watchdog_rate_field <= 2'h0;
		end else begin
			mux_sel <= st_d == sac_pkg::ST_IDLE ? mux_sel : ch_q;
			if (start) begin
				mux_sel <= pwdata[sac_pkg::CH_LSB +: sac_pkg::CH_W];
			end
			dac_code <= sar_d;
			sample_gate <= st_d == sac_pkg::ST_SAMPLE;
			pump_enable <= opt_d.pwr_up;
			pump_alt_clock <= opt_d.alt_clk;
			irq_edge_select <= opt_d.irq_edge;
			stop_recovery_delay <= opt_d.stop_dly;
			watchdog_rate_field <= opt_d.wdog_rate;
		end
	end

	// ----------------------------------------
	// APB read data and handshake
	// ----------------------------------------
	wire busy = st_q != sac_pkg::ST_IDLE;
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h0000_0000;
		if (hit_opt) begin
			rd_val[7:0] = opt_q;
		end else if (hit_ctrl) begin
			rd_val[sac_pkg::CH_LSB +: sac_pkg::CH_W] = ch_q;
		end else if (hit_stat) begin
			rd_val[sac_pkg::STAT_DONE_BIT] = done_q;
			rd_val[sac_pkg::STAT_BUSY_BIT] = busy;
		end else if (hit_res) begin
			rd_val[7:0] = res_q[paddr[4:2]];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pready_q <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready_q <= psel & ~penable;
			prdata <= rd_val;
			pslverr <= psel & ~penable & ~mapped;
		end
	end
	assign pready = pready_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_convert;
		start ##1 (st_q == sac_pkg::ST_SAMPLE);
	endsequence

	property p_start_clears_done;
		@(posedge ref_clk) disable iff (rst) start & ~last |=> !done_q;
	endproperty
	a_start_clears_done: assert property (p_start_clears_done)
		else $error("done flag not cleared at start");

	property p_done_with_result;
		@(posedge ref_clk) disable iff (rst)
			last && !start |=> done_q && res_q[ch_q[2:0]] == $past(sar_d);
	endproperty
	a_done_with_result: assert property (p_done_with_result)
		else $error("result not stored with done flag");

	property p_msb_first;
		@(posedge ref_clk) disable iff (rst)
			(st_q == sac_pkg::ST_SAMPLE) && step && !start && opt_q.pwr_up
			|=> dac_code == 8'h80 && bit_q == 3'h7;
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("compare does not begin at MSB");

	property p_gate_only_sampling;
		@(posedge ref_clk) disable iff (rst)
			sample_gate |-> $past(st_d) == sac_pkg::ST_SAMPLE;
	endproperty
	a_gate_only_sampling: assert property (p_gate_only_sampling)
		else $error("sample gate outside sampling");

	property p_unpowered_idle;
		@(posedge ref_clk) disable iff (rst)
			!opt_q.pwr_up && !wr_opt |=> st_q == sac_pkg::ST_IDLE && !pump_enable;
	endproperty
	a_unpowered_idle: assert property (p_unpowered_idle)
		else $error("converter active while unpowered");

	property p_prot_locked;
		@(posedge ref_clk) disable iff (rst)
			wr_opt && !prot_open |=> $stable(watchdog_rate_field) && $stable(irq_edge_select);
	endproperty
	a_prot_locked: assert property (p_prot_locked)
		else $error("protected bits changed while locked");

	property p_prot_once;
		@(posedge ref_clk) disable iff (rst)
			wr_opt && !special_q && mode_taken_q |=> !prot_open;
	endproperty
	a_prot_once: assert property (p_prot_once)
		else $error("protected bits writable twice");

	property p_channel_routed;
		@(posedge ref_clk) disable iff (rst)
			s_convert |-> mux_sel == ch_q;
	endproperty
	a_channel_routed: assert property (p_channel_routed)
		else $error("mux not on selected channel");

	property p_alt_clock_steps;
		@(posedge ref_clk) disable iff (rst)
			opt_q.alt_clk && !rc_tick && st_q == sac_pkg::ST_COMPARE && !start
			|=> $stable(bit_q);
	endproperty
	a_alt_clock_steps: assert property (p_alt_clock_steps)
		else $error("step taken without RC tick");
endmodule : sac_top

// ---- verification/sac_analog_model.sv ----
// Analog front end: sixteen mux inputs, sample-hold and comparator.
// Assumes the bench sets input levels; the RC oscillator runs free.
module sac_analog_model (
	input wire logic [15:0][7:0] levels,
	input wire logic [sac_pkg::CH_W-1:0] mux_sel,
	input wire logic [7:0] dac_code,
	input wire logic sample_gate,
	input wire logic pump_enable,
	output logic comp_pin,
	output logic rc_osc_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] held = 8'h00;

	// ----------------------------------------
	// RC oscillator
	// ----------------------------------------
	initial begin
		rc_osc_pin = 1'b0;
		forever #23 rc_osc_pin = ~rc_osc_pin;
	end

	// ----------------------------------------
	// Sample-hold and comparator
	// ----------------------------------------
	always @(sample_gate, pump_enable, mux_sel, levels) begin
		if (sample_gate && pump_enable) begin
			held = levels[mux_sel];
		end
	end
	assign comp_pin = pump_enable ? (held >= dac_code) : rc_osc_pin;
endmodule : sac_analog_model

// ---- verification/testbench.sv ----
// Self-checking bench for the converter control block.
// Assumes the analog front end model and an APB master in the bench.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [3:0] ch; logic [7:0] lvl;} sac_row_type;
	logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, comp_pin, rc_osc_pin, err;
	logic special_mode;
	logic sample_gate, pump_enable, pump_alt_clock, irq_edge_select, stop_recovery_delay;
	logic [1:0] watchdog_rate_field;
	logic [7:0] paddr, dac_code;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] mux_sel;
	logic [15:0][7:0] levels;
	int fail_count, n_compared;
	sac_row_type rows[9] = '{'{4'h0, 8'h00}, '{4'h1, 8'hff}, '{4'h2, 8'h80}, '{4'h3, 8'h7f},
		'{4'h4, 8'h55}, '{4'h5, 8'haa}, '{4'h6, 8'h01}, '{4'h7, 8'hfe}, '{4'hc, 8'h96}};

	sac_top #(.BUS_DIV(4)) i_sac_top (.ref_clk(ref_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .special_mode_pin(special_mode),
		.rc_osc_pin(rc_osc_pin),
		.comp_pin(comp_pin), .mux_sel(mux_sel), .dac_code(dac_code), .sample_gate(sample_gate),
		.pump_enable(pump_enable), .pump_alt_clock(pump_alt_clock),
		.irq_edge_select(irq_edge_select), .stop_recovery_delay(stop_recovery_delay),
		.watchdog_rate_field(watchdog_rate_field));
	sac_analog_model i_sac_analog_model (.levels(levels), .mux_sel(mux_sel),
		.dac_code(dac_code), .sample_gate(sample_gate), .pump_enable(pump_enable),
		.comp_pin(comp_pin), .rc_osc_pin(rc_osc_pin));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(negedge ref_clk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(negedge ref_clk);
		end
		chk("pready", 32'h0000_0001, {31'h0, pready});
		rd = prdata;
		err = pslverr;
		@(posedge ref_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge ref_clk);
	endtask : apb

	task automatic convert(input logic [3:0] ch);
		int n = 0;
		apb(1'b1, sac_pkg::CTRL_OFS, {28'h000_0000, ch});
		apb(1'b0, sac_pkg::STAT_OFS, 32'h0000_0000);
		chk("done on start", 32'h0000_0000, {31'h0, rd[sac_pkg::STAT_DONE_BIT]});
		while (rd[sac_pkg::STAT_DONE_BIT] !== 1'b1 && n < 300) begin
			apb(1'b0, sac_pkg::STAT_OFS, 32'h0000_0000);
			n++;
		end
		chk("done at end", 32'h0000_0001, {31'h0, rd[sac_pkg::STAT_DONE_BIT]});
		apb(1'b0, sac_pkg::RES_OFS + {3'h0, ch[2:0], 2'h0}, 32'h0000_0000);
	endtask : convert

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	// ----------------------------------------
	// Clock, watchdog and sequence
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (60000) @(posedge ref_clk);
		fail_count++;
		wrap_up();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, levels, special_mode} = '0;
		rst = 1'b1;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk("pump after reset", 32'h0000_0000, {31'h0, pump_enable});
		apb(1'b0, sac_pkg::OPT_OFS, 32'h0000_0000);
		chk("option reset", {24'h00_0000, sac_pkg::OPT_RST}, rd);
		apb(1'b1, sac_pkg::OPT_OFS, 32'h0000_00a3);
		apb(1'b1, sac_pkg::OPT_OFS, 32'h0000_0080);
		apb(1'b0, sac_pkg::OPT_OFS, 32'h0000_0000);
		chk("option locked", 32'h0000_00a3, rd);
		chk("protected pins", 32'h0000_0007, {29'h0, irq_edge_select, watchdog_rate_field});
		repeat (sac_pkg::SETTLE_CYC) @(posedge ref_clk);
		foreach (rows[i]) begin
			levels[rows[i].ch] <= rows[i].lvl;
			convert(rows[i].ch);
			chk("result", {24'h00_0000, rows[i].lvl}, rd);
		end
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, {31'h0, err});
		apb(1'b1, sac_pkg::OPT_OFS, 32'h0000_00c0);
		chk("alt clock pin", 32'h0000_0001, {31'h0, pump_alt_clock});
		levels[5] <= 8'h3c;
		convert(4'h5);
		chk("rc result", 32'h0000_003c, rd);
		apb(1'b1, sac_pkg::CTRL_OFS, 32'h0000_0003);
		apb(1'b1, sac_pkg::OPT_OFS, 32'h0000_0000);
		chk("pump off", 32'h0000_0000, {31'h0, pump_enable});
		apb(1'b1, sac_pkg::CTRL_OFS, 32'h0000_0006);
		apb(1'b0, sac_pkg::STAT_OFS, 32'h0000_0000);
		chk("abort unpowered", 32'h0000_0000, {31'h0, rd[sac_pkg::STAT_BUSY_BIT]});
		apb(1'b0, sac_pkg::CTRL_OFS, 32'h0000_0000);
		chk("no start unpowered", 32'h0000_0003, rd);
		apb(1'b1, sac_pkg::OPT_OFS, 32'h0000_0080);
		@(posedge ref_clk);
		special_mode <= 1'b1;
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk("pump mid reset", 32'h0000_0000, {31'h0, pump_enable});
		apb(1'b0, sac_pkg::OPT_OFS, 32'h0000_0000);
		chk("option mid reset", {24'h00_0000, sac_pkg::OPT_RST}, rd);
		apb(1'b1, sac_pkg::OPT_OFS, 32'h0000_0001);
		repeat (70) @(posedge ref_clk);
		apb(1'b1, sac_pkg::OPT_OFS, 32'h0000_0022);
		apb(1'b0, sac_pkg::OPT_OFS, 32'h0000_0000);
		chk("special unlocked", 32'h0000_0022, rd);
		wrap_up();
	end
endmodule : testbench
